//--- pkg/lrl_pkg.sv
package lrl_pkg;
   localparam int RAM_WORDS        = 60;
   localparam int RAM_BITS         = 4;
   localparam int PTR_W            = 6;
   localparam int SUB_W            = 3;
   localparam int COL_W            = 2;
   localparam int BIT_IDX_W        = 3;
   localparam int PLEN_W           = 5;
   localparam int FRAME_DIV        = 24;
   localparam int NOMINAL_FRAME_HZ = 64;
   localparam int SYNC_STAGES      = 3;

   typedef enum logic [1:0] {
      LRL_STATIC = 2'h0,
      LRL_MUX2   = 2'h1,
      LRL_MUX3   = 2'h2,
      LRL_MUX4   = 2'h3
   } lrl_mode_t;

   localparam logic [PTR_W-1:0]     PTR_RST    = 6'h00;
   localparam logic [SUB_W-1:0]     SUB_RST    = 3'h0;
   localparam logic [PTR_W-1:0]     INC_STATIC = 6'h08;
   localparam logic [PTR_W-1:0]     INC_MUX2   = 6'h04;
   localparam logic [PTR_W-1:0]     INC_MUX3   = 6'h03;
   localparam logic [PTR_W-1:0]     INC_MUX4   = 6'h02;
   localparam logic [BIT_IDX_W-1:0] BIT_LAST   = 3'h7;
   localparam logic [2:0]           NPH_STATIC = 3'h1;
   localparam logic [2:0]           NPH_MUX2   = 3'h2;
   localparam logic [2:0]           NPH_MUX3   = 3'h3;
   localparam logic [2:0]           NPH_MUX4   = 3'h4;
endpackage

//--- src/lrl_ram.sv
`timescale 1ns/1ps
module lrl_ram #(
   parameter int WORDS = 60,
   parameter int BITS  = 4,
   parameter int AW    = 6,
   parameter int CW    = 2
) (
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   input  wire logic             we_in,
   input  wire logic [AW-1:0]    waddr_in,
   input  wire logic [CW-1:0]    wbit_in,
   input  wire logic             wdata_in,
   input  wire logic [CW-1:0]    rcol_in,
   output logic      [WORDS-1:0] col_out
);
   // No reset on the array: contents are undefined until loaded
   logic [BITS-1:0] mem_q [WORDS];

   if (WORDS > (1 << AW) || BITS > (1 << CW)) begin : g_chk
      $error("lrl_ram: address widths too small");
   end

   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem_q[waddr_in][wbit_in] <= wdata_in;
      end
   end

   // Whole column read at once so a phase change needs one cycle
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         col_out <= '0;
      end else begin
         for (int i = 0; i < WORDS; i++) begin
            col_out[i] <= mem_q[i][rcol_in];
         end
      end
   end
endmodule

//--- src/lrl_loader.sv
`timescale 1ns/1ps
module lrl_loader (
   input  wire logic                                  core_clk_in,
   input  wire logic                                  reset_in,
   input  wire logic [1:0]                            drive_mode_in,
   input  wire logic                                  ptr_load_in,
   input  wire logic [lrl_pkg::PTR_W-1:0]             ptr_value_in,
   input  wire logic                                  dev_sel_in,
   input  wire logic [lrl_pkg::SUB_W-1:0]             dev_sel_value_in,
   input  wire logic                                  data_bit_valid_in,
   input  wire logic                                  data_bit_in,
   input  wire logic                                  xfer_abort_in,
   input  wire logic [lrl_pkg::SUB_W-1:0]             hw_subaddr_pins_in,
   input  wire logic                                  sync_n_in,
   output logic                                       sync_n_out,
   output logic      [lrl_pkg::RAM_WORDS-1:0]         segment_outputs_out,
   output logic      [lrl_pkg::RAM_BITS-1:0]          backplane_outputs_out,
   output logic      [lrl_pkg::PTR_W-1:0]             data_ptr_out,
   output logic      [lrl_pkg::SUB_W-1:0]             subaddr_cnt_out
);
   localparam int PW = lrl_pkg::PTR_W;
   localparam int SW = lrl_pkg::SUB_W;
   localparam int BW = lrl_pkg::BIT_IDX_W;
   localparam int LW = lrl_pkg::PLEN_W;
   localparam int CW = lrl_pkg::COL_W;
   localparam int NW = lrl_pkg::RAM_WORDS;

   if (lrl_pkg::FRAME_DIV % 12 != 0 || lrl_pkg::FRAME_DIV >= (1 << LW)) begin : g_chk
      $error("lrl_loader: frame divider must split into 1 to 4 equal phases");
   end

   // ---------------- Functions ----------------
   function automatic logic [2:0] nphases(input lrl_pkg::lrl_mode_t m);
      unique case (m)
         lrl_pkg::LRL_STATIC: nphases = lrl_pkg::NPH_STATIC;
         lrl_pkg::LRL_MUX2:   nphases = lrl_pkg::NPH_MUX2;
         lrl_pkg::LRL_MUX3:   nphases = lrl_pkg::NPH_MUX3;
         lrl_pkg::LRL_MUX4:   nphases = lrl_pkg::NPH_MUX4;
      endcase
   endfunction

   function automatic logic [PW-1:0] ptr_step(input lrl_pkg::lrl_mode_t m);
      unique case (m)
         lrl_pkg::LRL_STATIC: ptr_step = lrl_pkg::INC_STATIC;
         lrl_pkg::LRL_MUX2:   ptr_step = lrl_pkg::INC_MUX2;
         lrl_pkg::LRL_MUX3:   ptr_step = lrl_pkg::INC_MUX3;
         lrl_pkg::LRL_MUX4:   ptr_step = lrl_pkg::INC_MUX4;
      endcase
   endfunction

   function automatic logic [LW-1:0] phase_len(input lrl_pkg::lrl_mode_t m);
      phase_len = LW'(lrl_pkg::FRAME_DIV / int'(nphases(m)));
   endfunction

   // Modulo-60 fold of a pointer sum; the sum never reaches twice the depth
   function automatic logic [PW-1:0] wrap_ptr(input logic [PW:0] s);
      wrap_ptr = (s >= (PW+1)'(NW)) ? PW'(s - (PW+1)'(NW)) : s[PW-1:0];
   endfunction

   function automatic logic ovf(input logic [PW:0] s);
      ovf = (s >= (PW+1)'(NW));
   endfunction

   function automatic logic [3:0] bp_map(input lrl_pkg::lrl_mode_t m,
                                         input logic [1:0] ph);
      logic [3:0] one;
      one = 4'h1 << ph;
      unique case (m)
         lrl_pkg::LRL_STATIC: bp_map = 4'hf;
         lrl_pkg::LRL_MUX2:   bp_map = {one[1:0], one[1:0]};
         lrl_pkg::LRL_MUX3:   bp_map = {one[1], one[2:0]};
         lrl_pkg::LRL_MUX4:   bp_map = one;
      endcase
   endfunction

   lrl_pkg::lrl_mode_t mode;
   assign mode = lrl_pkg::lrl_mode_t'(drive_mode_in);

   // ---------------- Pin synchronisers ----------------
   logic [SW-1:0] hw_s1_q;
   logic [SW-1:0] hw_s2_q;
   logic [SW-1:0] hw_s3_q;
   logic [SW-1:0] hw_sub_q;
   logic          sy_s1_q;
   logic          sy_s2_q;
   logic          sy_s3_q;
   logic          sync_lvl_q;
   logic          sync_hit;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         hw_s1_q    <= '0;
         hw_s2_q    <= '0;
         hw_s3_q    <= '0;
         hw_sub_q   <= '0;
         sy_s1_q    <= 1'b1;
         sy_s2_q    <= 1'b1;
         sy_s3_q    <= 1'b1;
         sync_lvl_q <= 1'b1;
      end else begin
         hw_s1_q <= hw_subaddr_pins_in;
         hw_s2_q <= hw_s1_q;
         hw_s3_q <= hw_s2_q;
         sy_s1_q <= sync_n_in;
         sy_s2_q <= sy_s1_q;
         sy_s3_q <= sy_s2_q;
         for (int i = 0; i < SW; i++) begin
            if (hw_s2_q[i] == hw_s3_q[i]) begin
               hw_sub_q[i] <= hw_s2_q[i];
            end
         end
         if (sy_s2_q == sy_s3_q) begin
            sync_lvl_q <= sy_s2_q;
         end
      end
   end

   // Falling edge of the filtered active-low sync
   assign sync_hit = sync_lvl_q && (sy_s2_q == sy_s3_q) && !sy_s2_q;

   // ---------------- Frame and phase timing ----------------
   logic [LW-1:0] div_q;
   logic [LW-1:0] div_d;
   logic [1:0]    phase_q;
   logic [1:0]    phase_d;
   logic [1:0]    phase_last;
   logic          phase_tick;
   logic          frame_start;
   logic          latch_load_q;
   logic [1:0]    rd_col;

   assign phase_last  = 2'(nphases(mode) - 3'h1);
   assign phase_tick  = (div_q >= phase_len(mode) - LW'(1));
   assign frame_start = phase_tick && (phase_q >= phase_last);
   assign div_d       = sync_hit ? phase_len(mode) - LW'(1) :
                        phase_tick ? '0 : div_q + LW'(1);
   assign phase_d     = sync_hit ? phase_last :
                        frame_start ? 2'h0 :
                        phase_tick ? phase_q + 2'h1 : phase_q;
   // Prefetch the coming column so the latch swaps right after the tick
   assign rd_col      = phase_tick ? phase_d : phase_q;

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         div_q        <= '0;
         phase_q      <= '0;
         latch_load_q <= 1'b0;
         sync_n_out   <= 1'b1;
      end else begin
         div_q        <= div_d;
         phase_q      <= phase_d;
         latch_load_q <= phase_tick && !sync_hit;
         sync_n_out   <= !(frame_start && !sync_hit);
      end
   end

   // ---------------- Write path ----------------
   logic [PW-1:0]  ptr_q;
   logic [PW-1:0]  ptr_d;
   logic [SW-1:0]  sub_q;
   logic [SW-1:0]  sub_d;
   logic [BW-1:0]  bit_cnt_q;
   logic [BW-1:0]  bit_cnt_d;
   logic [BW-1:0]  word_off;
   logic [1:0]     word_bit;
   logic [PW:0]    wr_sum;
   logic [PW:0]    step_sum;
   logic [PW-1:0]  wr_addr;
   logic [SW-1:0]  eff_sub;
   logic           sub_match;
   logic           ram_we;
   logic           byte_done;

   assign word_off  = BW'(bit_cnt_q / nphases(mode));
   assign word_bit  = 2'(bit_cnt_q % nphases(mode));
   assign wr_sum    = {1'b0, ptr_q} + {{(PW+1-BW){1'b0}}, word_off};
   assign wr_addr   = wrap_ptr(wr_sum);
   assign eff_sub   = sub_q + SW'(ovf(wr_sum));
   assign sub_match = (eff_sub == hw_sub_q);
   // Write each bit whose subaddress matches on arrival, not at the byte acknowledge
   assign ram_we    = data_bit_valid_in && !ptr_load_in && !xfer_abort_in && sub_match;
   assign byte_done = data_bit_valid_in && (bit_cnt_q == lrl_pkg::BIT_LAST);
   assign step_sum  = {1'b0, ptr_q} + {1'b0, ptr_step(mode)};

   always_comb begin
      ptr_d     = ptr_q;
      sub_d     = sub_q;
      bit_cnt_d = bit_cnt_q;
      if (ptr_load_in) begin
         ptr_d     = wrap_ptr({1'b0, ptr_value_in});
         bit_cnt_d = '0;
      end else if (xfer_abort_in) begin
         bit_cnt_d = '0;
      end else if (data_bit_valid_in) begin
         bit_cnt_d = bit_cnt_q + BW'(1);
         if (byte_done) begin
            ptr_d = wrap_ptr(step_sum);
            sub_d = sub_q + SW'(ovf(step_sum));
         end
      end
      if (dev_sel_in) begin
         sub_d = dev_sel_value_in;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         ptr_q     <= lrl_pkg::PTR_RST;
         sub_q     <= lrl_pkg::SUB_RST;
         bit_cnt_q <= '0;
      end else begin
         ptr_q     <= ptr_d;
         sub_q     <= sub_d;
         bit_cnt_q <= bit_cnt_d;
      end
   end

   assign data_ptr_out    = ptr_q;
   assign subaddr_cnt_out = sub_q;

   // ---------------- Display RAM, latch and drivers ----------------
   logic [NW-1:0] col_data;

   lrl_ram #(
      .WORDS (NW),
      .BITS  (lrl_pkg::RAM_BITS),
      .AW    (PW),
      .CW    (CW)
   ) u_ram (
      .clk_in   (core_clk_in),
      .reset_in (reset_in),
      .we_in    (ram_we),
      .waddr_in (wr_addr),
      .wbit_in  (word_bit),
      .wdata_in (data_bit_in),
      .rcol_in  (rd_col),
      .col_out  (col_data)
   );

   always_ff @(posedge core_clk_in) begin
      if (reset_in) begin
         segment_outputs_out   <= '0;
         backplane_outputs_out <= '0;
      end else if (latch_load_q) begin
         segment_outputs_out   <= col_data;
         backplane_outputs_out <= bp_map(mode, phase_q);
      end
   end

   // ---------------- Assertions ----------------
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (reset_in);

   logic mode_chg_q;
   logic [1:0] mode_prev_q;
   always_ff @(posedge core_clk_in) begin
      mode_prev_q <= drive_mode_in;
   end
   assign mode_chg_q = (mode_prev_q != drive_mode_in);

   a_frame_period: assert property (disable iff (reset_in || sync_hit || mode_chg_q)
      frame_start |-> ##24 frame_start)
      else $error("frame period is not 24 cycles");
   a_frame_quiet: assert property (disable iff (reset_in || sync_hit || mode_chg_q)
      frame_start |=> !frame_start [*8])
      else $error("frame start repeated too soon");
   a_sync_align: assert property (sync_hit && !mode_chg_q |=> ##1 (phase_q == 2'h0))
      else $error("sync did not restart the phase sequence");
   a_latch_hold: assert property (!latch_load_q |=>
      $stable(segment_outputs_out))
      else $error("display latch changed inside a phase");
   a_latch_load: assert property (latch_load_q |=>
      segment_outputs_out == $past(col_data))
      else $error("latch did not take the column");
   a_bp_mux3: assert property (latch_load_q && mode == lrl_pkg::LRL_MUX3 |=>
      backplane_outputs_out[3] == backplane_outputs_out[1])
      else $error("1:3 backplane 3 differs from 1");
   a_bp_mux2: assert property (latch_load_q && mode == lrl_pkg::LRL_MUX2 |=>
      backplane_outputs_out[3:2] == backplane_outputs_out[1:0])
      else $error("1:2 backplane pairs differ");
   a_bp_static: assert property (latch_load_q && mode == lrl_pkg::LRL_STATIC |=>
      backplane_outputs_out == 4'hf)
      else $error("static backplanes differ");
   a_write_now: assert property (data_bit_valid_in && !ptr_load_in && !xfer_abort_in
      && eff_sub == hw_sub_q |-> ram_we)
      else $error("arriving bit not written at once");
   a_write_block: assert property (eff_sub != hw_sub_q |-> !ram_we)
      else $error("write despite subaddress mismatch");
   a_ptr_advance: assert property (byte_done && !ptr_load_in && !xfer_abort_in |=>
      ptr_q == wrap_ptr({1'b0, $past(ptr_q)} + {1'b0, ptr_step(lrl_pkg::lrl_mode_t'($past(drive_mode_in)))}))
      else $error("pointer step wrong");
   a_sub_step: assert property (byte_done && !ptr_load_in && !xfer_abort_in
      && !dev_sel_in && ovf(step_sum) |=> sub_q == $past(sub_q) + 3'h1)
      else $error("subaddress not advanced on overflow");
   a_ptr_range: assert property (ptr_q < 6'h3c)
      else $error("pointer beyond last address");
   a_sub_load: assert property (dev_sel_in |=> sub_q == $past(dev_sel_value_in))
      else $error("device select not loaded");
   a_reset_clear: assert property ($past(reset_in) |-> ptr_q == 6'h00 && sub_q == 3'h0)
      else $error("reset did not clear pointer state");

   c_byte_mux3: cover property (byte_done && mode == lrl_pkg::LRL_MUX3);
   c_mid_byte_ovf: cover property (data_bit_valid_in && ovf(wr_sum) && bit_cnt_q != 3'h0);
   c_sync_seen: cover property (sync_hit);
   c_skip_write: cover property (data_bit_valid_in && !sub_match);
endmodule

//--- verif/lrl_host_model.sv
`timescale 1ns/1ps
module lrl_host_model (
   input  wire logic                      core_clk_in,
   output logic                           ptr_load_out,
   output logic [lrl_pkg::PTR_W-1:0]      ptr_value_out,
   output logic                           dev_sel_out,
   output logic [lrl_pkg::SUB_W-1:0]      dev_sel_value_out,
   output logic                           bit_valid_out,
   output logic                           bit_out,
   output logic                           abort_out
);
   initial begin
      ptr_load_out = 1'b0;
      ptr_value_out = 6'h00;
      dev_sel_out = 1'b0;
      dev_sel_value_out = 3'h0;
      bit_valid_out = 1'b0;
      bit_out = 1'b0;
      abort_out = 1'b0;
   end
   // Released data lines invert so a stale value never looks fresh; strobes drop low
   task automatic release_all();
      @(posedge core_clk_in);
      #2;
      ptr_load_out = 1'b0;
      dev_sel_out = 1'b0;
      bit_valid_out = 1'b0;
      abort_out = 1'b0;
      bit_out = ~bit_out;
      ptr_value_out = ~ptr_value_out;
      dev_sel_value_out = ~dev_sel_value_out;
   endtask
   task automatic load_ptr(input logic [lrl_pkg::PTR_W-1:0] v);
      @(posedge core_clk_in);
      #2;
      ptr_value_out = v;
      ptr_load_out = 1'b1;
      release_all();
   endtask
   task automatic select_dev(input logic [lrl_pkg::SUB_W-1:0] v);
      @(posedge core_clk_in);
      #2;
      dev_sel_value_out = v;
      dev_sel_out = 1'b1;
      release_all();
   endtask
   // First bit on the wire is the byte's top bit; valid stays up between bits
   task automatic send_bits(input logic [7:0] b, input int cnt);
      for (int k = 0; k < cnt; k++) begin
         @(posedge core_clk_in);
         #2;
         bit_out = b[7-k];
         bit_valid_out = 1'b1;
      end
      release_all();
   endtask
   // Caller must reload the pointer before the next byte
   task automatic abort_xfer();
      @(posedge core_clk_in);
      #2;
      abort_out = 1'b1;
      release_all();
   endtask
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam int TIMEOUT_CYCLES = 20000;
   logic        core_clk_in = 1'b0;
   logic        reset_in = 1'b1;
   logic [1:0]  drive_mode_in = 2'h3;
   logic [2:0]  hw_subaddr_pins_in = 3'h0;
   logic        sync_n_in = 1'b1;
   logic        ptr_load, dev_sel, bit_valid, data_bit, xfer_abort, sync_n_out;
   logic [5:0]  ptr_value, data_ptr_out, exp_ptr;
   logic [2:0]  dev_sel_value, subaddr_cnt_out, exp_sub;
   logic [59:0] segment_outputs_out;
   logic [3:0]  backplane_outputs_out;
   logic [3:0]  mem [60];
   logic [8:0]  notes [$];
   logic [8:0]  last_note = 9'h000;
   logic [8:0]  prev_seen;
   logic [5:0]  incs [4] = '{lrl_pkg::INC_STATIC, lrl_pkg::INC_MUX2, lrl_pkg::INC_MUX3, lrl_pkg::INC_MUX4};
   int          mismatches = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          seed = 38480;
   int          t;

   always #12.5 core_clk_in = ~core_clk_in;

   lrl_host_model lrl_host_model_inst (.core_clk_in(core_clk_in), .ptr_load_out(ptr_load),
      .ptr_value_out(ptr_value), .dev_sel_out(dev_sel), .dev_sel_value_out(dev_sel_value),
      .bit_valid_out(bit_valid), .bit_out(data_bit), .abort_out(xfer_abort));

   lrl_loader lrl_loader_inst (.core_clk_in(core_clk_in), .reset_in(reset_in), .drive_mode_in(drive_mode_in),
      .ptr_load_in(ptr_load), .ptr_value_in(ptr_value), .dev_sel_in(dev_sel), .dev_sel_value_in(dev_sel_value),
      .data_bit_valid_in(bit_valid), .data_bit_in(data_bit), .xfer_abort_in(xfer_abort),
      .hw_subaddr_pins_in(hw_subaddr_pins_in), .sync_n_in(sync_n_in), .sync_n_out(sync_n_out),
      .segment_outputs_out(segment_outputs_out), .backplane_outputs_out(backplane_outputs_out),
      .data_ptr_out(data_ptr_out), .subaddr_cnt_out(subaddr_cnt_out));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic note_state();
      if ({exp_sub, exp_ptr} !== last_note) begin
         last_note = {exp_sub, exp_ptr};
         notes.push_back(last_note);
      end
   endtask

   task automatic load(input logic [5:0] v);
      exp_ptr = v;
      note_state();
      lrl_host_model_inst.load_ptr(v);
   endtask

   task automatic select(input logic [2:0] v);
      exp_sub = v;
      note_state();
      lrl_host_model_inst.select_dev(v);
   endtask

   // Shadow RAM follows the fill order; bits past address 59 belong to the next subaddress
   task automatic send(input int cnt);
      int n;
      int a;
      logic [2:0] s;
      logic [7:0] b;
      n = int'(drive_mode_in) + 1;
      b = 8'($random(seed));
      for (int k = 0; k < cnt; k++) begin
         a = int'(exp_ptr) + k / n;
         s = exp_sub;
         if (a >= 60) begin
            a -= 60;
            s++;
         end
         if (s == hw_subaddr_pins_in) mem[a][k % n] = b[7-k];
      end
      if (cnt == 8) begin
         a = int'(exp_ptr) + int'(incs[drive_mode_in]);
         if (a >= 60) begin
            a -= 60;
            exp_sub++;
         end
         exp_ptr = 6'(a);
         note_state();
      end
      lrl_host_model_inst.send_bits(b, cnt);
   endtask

   function automatic logic [3:0] bp_pattern(input int n, input int p);
      case (n)
         1: return 4'hf;
         2: return (p == 0) ? 4'h5 : 4'ha;
         3: return (p == 1) ? 4'ha : ((p == 0) ? 4'h1 : 4'h4);
         default: return 4'h1 << p;
      endcase
   endfunction

   // Full frame first so every phase is latched after the last write
   task automatic check_display();
      logic [59:0] col;
      int n;
      int w;
      n = int'(drive_mode_in) + 1;
      repeat (26) @(posedge core_clk_in);
      // Look off the launch edge so latch and backplanes are settled
      @(negedge core_clk_in);
      for (int p = 0; p < n; p++) begin
         for (w = 0; w < 40 && backplane_outputs_out !== bp_pattern(n, p); w++) @(negedge core_clk_in);
         for (int i = 0; i < 60; i++) col[i] = mem[i][p];
         check(backplane_outputs_out, bp_pattern(n, p));
         check(segment_outputs_out, col);
      end
   endtask

   always @(negedge core_clk_in) begin
      if (reset_in) prev_seen = {subaddr_cnt_out, data_ptr_out};
      else if ({subaddr_cnt_out, data_ptr_out} !== prev_seen) begin
         prev_seen = {subaddr_cnt_out, data_ptr_out};
         check(prev_seen, (notes.size() > 0) ? notes.pop_front() : last_note);
      end
   end

   always @(posedge core_clk_in) begin
      cycles++;
      if (cycles >= TIMEOUT_CYCLES) begin
         mismatches++;
         $display("timeout after %0d cycles", cycles);
         print_verdict();
      end
   end

   initial begin
      exp_ptr = 6'h00;
      exp_sub = 3'h0;
      repeat (3) @(posedge core_clk_in);
      #2;
      reset_in = 1'b0;
      @(negedge core_clk_in);
      check(data_ptr_out, 6'h00);
      check(subaddr_cnt_out, 3'h0);
      check(sync_n_out, 1'b1);
      $display("test reset done");
      select(3'h0);
      load(6'h00);
      repeat (30) send(8);
      check_display();
      $display("test fill done");
      @(negedge sync_n_out);
      // Sync stays low through this first negedge
      @(negedge core_clk_in);
      t = 1;
      @(negedge core_clk_in);
      while (sync_n_out !== 1'b0 && t < 60) begin
         t++;
         @(negedge core_clk_in);
      end
      check(t, 24);
      // Sync just after phase 2 starts; free running would need at least 12 cycles
      for (t = 0; t < 40 && backplane_outputs_out !== 4'h4; t++) @(negedge core_clk_in);
      @(posedge core_clk_in);
      #2;
      sync_n_in = 1'b0;
      for (t = 0; t < 10 && backplane_outputs_out !== 4'h1; t++) @(negedge core_clk_in);
      check(t < 10, 1'b1);
      @(posedge core_clk_in);
      #2;
      sync_n_in = 1'b1;
      $display("test frame done");
      for (int m = 0; m < 3; m++) begin
         @(posedge core_clk_in);
         #2;
         drive_mode_in = 2'(m);
         select(3'h0);
         load(6'h39);
         repeat (2) send(8);
         check_display();
      end
      $display("test modes done");
      @(posedge core_clk_in);
      #2;
      hw_subaddr_pins_in = 3'h1;
      drive_mode_in = 2'h3;
      repeat (6) @(posedge core_clk_in);
      select(3'h0);
      load(6'h3b);
      send(8);
      load(6'h0a);
      send(3);
      lrl_host_model_inst.abort_xfer();
      load(6'h0a);
      send(8);
      check_display();
      check(notes.size(), 0);
      $display("test handover done");
      print_verdict();
   end
endmodule
